//--- design/ppsel_pkg.sv
// Package for the pin position selector: register offsets, field positions, reset values.
// Assumes a byte-wide register port and one clock domain.
package ppsel_pkg;

  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [1:0] MISC_ROUTE_OFS = 2'h0;
  localparam logic [1:0] SERIAL_ROUTE_OFS = 2'h1;
  localparam logic [1:0] TIMER_A_ROUTE_OFS = 2'h2;
  localparam logic [1:0] TIMER_B_ROUTE_OFS = 2'h3;

  // Reset values
  localparam logic [7:0] MISC_ROUTE_RST = 8'h00;
  localparam logic [7:0] SERIAL_ROUTE_RST = 8'h00;
  localparam logic [7:0] TIMER_A_ROUTE_RST = 8'h00;
  localparam logic [7:0] TIMER_B_ROUTE_RST = 8'h00;

  // Writable bit masks; other positions read zero
  localparam logic [7:0] MISC_ROUTE_MASK = 8'hb7;
  localparam logic [7:0] SERIAL_ROUTE_MASK = 8'h15;
  localparam logic [7:0] TIMER_A_ROUTE_MASK = 8'h3f;
  localparam logic [7:0] TIMER_B_ROUTE_MASK = 8'h01;

  // Field positions in misc_output_route_control
  localparam int unsigned BREAK_PIN_ALT_SELECT_POS = 7;
  localparam int unsigned LOGIC_TABLE_ONE_ALT_SELECT_POS = 5;
  localparam int unsigned LOGIC_TABLE_ZERO_ALT_SELECT_POS = 4;
  localparam int unsigned EVENT_PIN_TWO_ENABLE_POS = 2;
  localparam int unsigned EVENT_PIN_ONE_ENABLE_POS = 1;
  localparam int unsigned EVENT_PIN_ZERO_ENABLE_POS = 0;

  // Field positions in serial_pin_route_control
  localparam int unsigned TWO_WIRE_ALT_SELECT_POS = 4;
  localparam int unsigned SPI_ALT_SELECT_POS = 2;
  localparam int unsigned SERIAL_TRANSCEIVER_ALT_SELECT_POS = 0;

  // Field positions in timer_b_output_route_control
  localparam int unsigned CAPTURE_TIMER_ALT_SELECT_POS = 0;

  // Number of compare timer waveform outputs
  localparam int unsigned WAVE_N = 6;
  localparam int unsigned WAVE_SPLIT_ONLY_LO = 3;

  // Default/alternative route of a single signal: {out_alt, out_default}, out_default in bit 0
  function automatic logic [1:0] ppsel_route(input logic sig, input logic alt);
    ppsel_route = alt ? {sig, 1'b0} : {1'b0, sig};
  endfunction

endpackage : ppsel_pkg

//--- design/ppsel_regs.sv
// Register file of the pin position selector: four byte registers on a plain port.
// Assumes single-cycle strobes from a master synchronous to ref_clk; read data one cycle later.
`timescale 1ns/100ps
`default_nettype none
module ppsel_regs (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic [7:0] misc_route_ff,
  output logic [7:0] serial_route_ff,
  output logic [7:0] timer_a_route_ff,
  output logic [7:0] timer_b_route_ff
);

  logic [7:0] nxt_rdata;

  // Unassigned bits are masked on write so they always hold zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      misc_route_ff <= ppsel_pkg::MISC_ROUTE_RST;
      serial_route_ff <= ppsel_pkg::SERIAL_ROUTE_RST;
      timer_a_route_ff <= ppsel_pkg::TIMER_A_ROUTE_RST;
      timer_b_route_ff <= ppsel_pkg::TIMER_B_ROUTE_RST;
    end else if (wr_stb) begin
      case (addr)
        ppsel_pkg::MISC_ROUTE_OFS: misc_route_ff <= wdata & ppsel_pkg::MISC_ROUTE_MASK;
        ppsel_pkg::SERIAL_ROUTE_OFS: serial_route_ff <= wdata & ppsel_pkg::SERIAL_ROUTE_MASK;
        ppsel_pkg::TIMER_A_ROUTE_OFS: timer_a_route_ff <= wdata & ppsel_pkg::TIMER_A_ROUTE_MASK;
        ppsel_pkg::TIMER_B_ROUTE_OFS: timer_b_route_ff <= wdata & ppsel_pkg::TIMER_B_ROUTE_MASK;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (addr)
      ppsel_pkg::MISC_ROUTE_OFS: nxt_rdata = misc_route_ff;
      ppsel_pkg::SERIAL_ROUTE_OFS: nxt_rdata = serial_route_ff;
      ppsel_pkg::TIMER_A_ROUTE_OFS: nxt_rdata = timer_a_route_ff;
      ppsel_pkg::TIMER_B_ROUTE_OFS: nxt_rdata = timer_b_route_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd_stb ? nxt_rdata : 8'h00;
    end
  end

endmodule // ppsel_regs
`default_nettype wire

//--- design/ppsel_top.sv
// Pin position selector: routes peripheral signals to default or alternative pins.
// Assumes peripheral signals synchronous to ref_clk; pin outputs lag inputs by one cycle.
`timescale 1ns/100ps
`default_nettype none
module ppsel_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // Compare timer split mode flag
  input wire logic timer_split_mode,
  // Break input from both pin positions, to the timer
  input wire logic break_pin_default_in,
  input wire logic break_pin_alt_in,
  output logic break_to_timer_ff,
  // Lookup table outputs
  input wire logic logic_table_zero_out,
  input wire logic logic_table_one_out,
  output logic logic_table_zero_default_pin_ff,
  output logic logic_table_zero_alt_pin_ff,
  output logic logic_table_one_default_pin_ff,
  output logic logic_table_one_alt_pin_ff,
  // Event outputs
  input wire logic [2:0] event_signals,
  output logic [2:0] event_output_pins_ff,
  // Two-wire: clock and data, open drain, enables active low
  input wire logic two_wire_scl_oe_n,
  input wire logic two_wire_sda_oe_n,
  output logic [1:0] two_wire_default_oe_n_ff,
  output logic [1:0] two_wire_alt_oe_n_ff,
  input wire logic [1:0] two_wire_default_pin_in,
  input wire logic [1:0] two_wire_alt_pin_in,
  output logic [1:0] two_wire_in_ff,
  // SPI: sck, mosi outgoing; miso, ss incoming
  input wire logic [1:0] spi_out,
  output logic [1:0] spi_default_pin_ff,
  output logic [1:0] spi_alt_pin_ff,
  input wire logic [1:0] spi_default_pin_in,
  input wire logic [1:0] spi_alt_pin_in,
  output logic [1:0] spi_in_ff,
  // Serial transceiver: transmit out, receive in
  input wire logic serial_tx,
  output logic serial_tx_default_pin_ff,
  output logic serial_tx_alt_pin_ff,
  input wire logic serial_rx_default_pin_in,
  input wire logic serial_rx_alt_pin_in,
  output logic serial_rx_ff,
  // Compare timer waveform outputs
  input wire logic [5:0] waveform_out,
  output logic [5:0] waveform_default_pin_ff,
  output logic [5:0] waveform_alt_pin_ff,
  // Capture timer waveform output
  input wire logic capture_timer_out,
  output logic capture_timer_default_pin_ff,
  output logic capture_timer_alt_pin_ff
);

  logic [7:0] misc_route_ff;
  logic [7:0] serial_route_ff;
  logic [7:0] timer_a_route_ff;
  logic [7:0] timer_b_route_ff;
  logic [1:0] nxt_lt0;
  logic [1:0] nxt_lt1;
  logic [1:0] nxt_tx;
  logic [1:0] nxt_cap;
  logic [5:0] wave_alt_eff;
  logic [2:0] event_enable;

  ppsel_regs u_regs (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .misc_route_ff(misc_route_ff),
    .serial_route_ff(serial_route_ff),
    .timer_a_route_ff(timer_a_route_ff),
    .timer_b_route_ff(timer_b_route_ff)
  );

  wire logic break_alt = misc_route_ff[ppsel_pkg::BREAK_PIN_ALT_SELECT_POS];
  wire logic lt1_alt = misc_route_ff[ppsel_pkg::LOGIC_TABLE_ONE_ALT_SELECT_POS];
  wire logic lt0_alt = misc_route_ff[ppsel_pkg::LOGIC_TABLE_ZERO_ALT_SELECT_POS];
  wire logic tw_alt = serial_route_ff[ppsel_pkg::TWO_WIRE_ALT_SELECT_POS];
  wire logic spi_alt = serial_route_ff[ppsel_pkg::SPI_ALT_SELECT_POS];
  wire logic tx_alt = serial_route_ff[ppsel_pkg::SERIAL_TRANSCEIVER_ALT_SELECT_POS];
  wire logic cap_alt = timer_b_route_ff[ppsel_pkg::CAPTURE_TIMER_ALT_SELECT_POS];

  always_comb begin
    event_enable = {misc_route_ff[ppsel_pkg::EVENT_PIN_TWO_ENABLE_POS],
                    misc_route_ff[ppsel_pkg::EVENT_PIN_ONE_ENABLE_POS],
                    misc_route_ff[ppsel_pkg::EVENT_PIN_ZERO_ENABLE_POS]};
    // Upper three selects only matter in split mode
    wave_alt_eff = {timer_a_route_ff[5:3] & {3{timer_split_mode}}, timer_a_route_ff[2:0]};
    nxt_lt0 = ppsel_pkg::ppsel_route(logic_table_zero_out, lt0_alt);
    nxt_lt1 = ppsel_pkg::ppsel_route(logic_table_one_out, lt1_alt);
    nxt_tx = ppsel_pkg::ppsel_route(serial_tx, tx_alt);
    nxt_cap = ppsel_pkg::ppsel_route(capture_timer_out, cap_alt);
  end

  // Break input
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      break_to_timer_ff <= 1'b0;
    end else begin
      break_to_timer_ff <= break_alt ? break_pin_alt_in : break_pin_default_in;
    end
  end

  // Lookup table outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      logic_table_zero_default_pin_ff <= 1'b0;
      logic_table_zero_alt_pin_ff <= 1'b0;
      logic_table_one_default_pin_ff <= 1'b0;
      logic_table_one_alt_pin_ff <= 1'b0;
    end else begin
      logic_table_zero_default_pin_ff <= nxt_lt0[0];
      logic_table_zero_alt_pin_ff <= nxt_lt0[1];
      logic_table_one_default_pin_ff <= nxt_lt1[0];
      logic_table_one_alt_pin_ff <= nxt_lt1[1];
    end
  end

  // Event outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      event_output_pins_ff <= 3'h0;
    end else begin
      event_output_pins_ff <= event_signals & event_enable;
    end
  end

  // Two-wire: the unselected position never pulls low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      two_wire_default_oe_n_ff <= 2'h3;
      two_wire_alt_oe_n_ff <= 2'h3;
      two_wire_in_ff <= 2'h3;
    end else begin
      two_wire_default_oe_n_ff <= tw_alt ? 2'h3 : {two_wire_sda_oe_n, two_wire_scl_oe_n};
      two_wire_alt_oe_n_ff <= tw_alt ? {two_wire_sda_oe_n, two_wire_scl_oe_n} : 2'h3;
      two_wire_in_ff <= tw_alt ? two_wire_alt_pin_in : two_wire_default_pin_in;
    end
  end

  // SPI
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      spi_default_pin_ff <= 2'h0;
      spi_alt_pin_ff <= 2'h0;
      spi_in_ff <= 2'h0;
    end else begin
      spi_default_pin_ff <= spi_alt ? 2'h0 : spi_out;
      spi_alt_pin_ff <= spi_alt ? spi_out : 2'h0;
      spi_in_ff <= spi_alt ? spi_alt_pin_in : spi_default_pin_in;
    end
  end

  // Serial transceiver
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      serial_tx_default_pin_ff <= 1'b0;
      serial_tx_alt_pin_ff <= 1'b0;
      serial_rx_ff <= 1'b0;
    end else begin
      serial_tx_default_pin_ff <= nxt_tx[0];
      serial_tx_alt_pin_ff <= nxt_tx[1];
      serial_rx_ff <= tx_alt ? serial_rx_alt_pin_in : serial_rx_default_pin_in;
    end
  end

  // Compare timer waveform outputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      waveform_default_pin_ff <= 6'h00;
      waveform_alt_pin_ff <= 6'h00;
    end else begin
      waveform_default_pin_ff <= waveform_out & ~wave_alt_eff;
      waveform_alt_pin_ff <= waveform_out & wave_alt_eff;
    end
  end

  // Capture timer output
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_timer_default_pin_ff <= 1'b0;
      capture_timer_alt_pin_ff <= 1'b0;
    end else begin
      capture_timer_default_pin_ff <= nxt_cap[0];
      capture_timer_alt_pin_ff <= nxt_cap[1];
    end
  end

  // Assertions; $past(rstn) skips the first edge after reset, where flops still show reset values
  break_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) |-> break_to_timer_ff == $past(break_alt ? break_pin_alt_in : break_pin_default_in))
    else $error("break input routed from wrong pin");

  lt1_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(lt1_alt) |-> (logic_table_one_alt_pin_ff == $past(logic_table_one_out)) && !logic_table_one_default_pin_ff)
    else $error("second table output on wrong pin");

  lt0_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && !$past(lt0_alt) |->
      (logic_table_zero_default_pin_ff == $past(logic_table_zero_out)) && !logic_table_zero_alt_pin_ff)
    else $error("first table output on wrong pin");

  event_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (event_output_pins_ff & ~$past(event_enable)) == 3'h0)
    else $error("disabled event pin driven");

  two_wire_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(tw_alt) |-> two_wire_default_oe_n_ff == 2'h3)
    else $error("two-wire default pins pulled while moved");

  spi_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(spi_alt) |-> spi_in_ff == $past(spi_alt_pin_in) && spi_default_pin_ff == 2'h0)
    else $error("spi not on alternative pins");

  tx_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(tx_alt) |-> serial_tx_alt_pin_ff == $past(serial_tx) && !serial_tx_default_pin_ff)
    else $error("transceiver not on alternative pins");

  wave_normal_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !$past(timer_split_mode) |-> waveform_alt_pin_ff[5:3] == 3'h0)
    else $error("upper waveform moved in normal mode");

  wave_low_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    waveform_alt_pin_ff[2:0] == ($past(waveform_out[2:0]) & $past(timer_a_route_ff[2:0])))
    else $error("lower waveform alternative routing wrong");

  cap_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    capture_timer_alt_pin_ff == ($past(capture_timer_out) & $past(cap_alt)))
    else $error("capture timer output routing wrong");

  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (misc_route_ff & ~ppsel_pkg::MISC_ROUTE_MASK) == 8'h00 && (serial_route_ff & ~ppsel_pkg::SERIAL_ROUTE_MASK) == 8'h00)
    else $error("reserved bits set");

  write_effect_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_stb && addr == ppsel_pkg::TIMER_B_ROUTE_OFS |=> timer_b_route_ff == ($past(wdata) & ppsel_pkg::TIMER_B_ROUTE_MASK))
    else $error("register write did not land next cycle");

  lt1_default_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && !$past(lt1_alt) |->
      logic_table_one_default_pin_ff == $past(logic_table_one_out) && !logic_table_one_alt_pin_ff)
    else $error("second table output not on default pin");

  lt0_alt_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(lt0_alt) |->
      logic_table_zero_alt_pin_ff == $past(logic_table_zero_out) && !logic_table_zero_default_pin_ff)
    else $error("first table output not on alternative pin");

  event_pass_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((event_output_pins_ff ^ $past(event_signals)) & $past(event_enable)) == 3'h0)
    else $error("enabled event pin lost its signal");

  two_wire_alt_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(tw_alt) |-> two_wire_alt_oe_n_ff == $past({two_wire_sda_oe_n, two_wire_scl_oe_n}) &&
      two_wire_in_ff == $past(two_wire_alt_pin_in))
    else $error("two-wire not on alternative pins");

  two_wire_default_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && !$past(tw_alt) |-> two_wire_alt_oe_n_ff == 2'h3 &&
      two_wire_default_oe_n_ff == $past({two_wire_sda_oe_n, two_wire_scl_oe_n}) &&
      two_wire_in_ff == $past(two_wire_default_pin_in))
    else $error("two-wire not on default pins");

  spi_default_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && !$past(spi_alt) |-> spi_default_pin_ff == $past(spi_out) &&
      spi_alt_pin_ff == 2'h0 && spi_in_ff == $past(spi_default_pin_in))
    else $error("spi not on default pins");

  tx_default_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && !$past(tx_alt) |-> serial_tx_default_pin_ff == $past(serial_tx) &&
      !serial_tx_alt_pin_ff && serial_rx_ff == $past(serial_rx_default_pin_in))
    else $error("transceiver not on default pins");

  wave_split_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && $past(timer_split_mode) |->
      waveform_alt_pin_ff[5:3] == ($past(waveform_out[5:3]) & $past(timer_a_route_ff[5:3])))
    else $error("upper waveform routing wrong in split mode");

  wave_share_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) |-> (waveform_default_pin_ff & waveform_alt_pin_ff) == 6'h00 &&
      (waveform_default_pin_ff | waveform_alt_pin_ff) == $past(waveform_out))
    else $error("waveform output lost or doubled");

  cap_default_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(rstn) && !$past(cap_alt) |->
      capture_timer_default_pin_ff == $past(capture_timer_out) && !capture_timer_alt_pin_ff)
    else $error("capture timer output not on default pin");

  reserved_upper_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (timer_a_route_ff & ~ppsel_pkg::TIMER_A_ROUTE_MASK) == 8'h00 &&
      (timer_b_route_ff & ~ppsel_pkg::TIMER_B_ROUTE_MASK) == 8'h00)
    else $error("reserved timer route bits set");

  // A register write lands at the next edge; pins follow one edge later
  sequence misc_write_s;
    wr_stb && addr == ppsel_pkg::MISC_ROUTE_OFS;
  endsequence

  sequence serial_write_s;
    wr_stb && addr == ppsel_pkg::SERIAL_ROUTE_OFS;
  endsequence

  sequence spi_alt_effect_s;
    spi_alt ##1 (spi_alt_pin_ff == $past(spi_out) && spi_default_pin_ff == 2'h0);
  endsequence

  misc_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    misc_write_s |=> misc_route_ff == ($past(wdata) & ppsel_pkg::MISC_ROUTE_MASK))
    else $error("misc route write did not land next cycle");

  spi_write_route_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    serial_write_s ##0 wdata[ppsel_pkg::SPI_ALT_SELECT_POS] |=> spi_alt_effect_s)
    else $error("spi select write did not reach the pins in time");

  read_data_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_stb && addr == ppsel_pkg::SERIAL_ROUTE_OFS |=> rdata == $past(serial_route_ff))
    else $error("read data wrong or late");

  read_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !rd_stb |=> rdata == 8'h00)
    else $error("read data outside the read cycle");

endmodule // ppsel_top
`default_nettype wire

//--- sim/ppsel_pin_model.sv
// Far-side model: peripheral outputs and pin levels around the pin position selector.
// Assumes the bench changes lvl just after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module ppsel_pin_model (
  input wire logic lvl,
  output logic break_pin_default_in,
  output logic break_pin_alt_in,
  output logic logic_table_zero_out,
  output logic logic_table_one_out,
  output logic [2:0] event_signals,
  output logic two_wire_scl_oe_n,
  output logic two_wire_sda_oe_n,
  output logic [1:0] two_wire_default_pin_in,
  output logic [1:0] two_wire_alt_pin_in,
  output logic [1:0] spi_out,
  output logic [1:0] spi_default_pin_in,
  output logic [1:0] spi_alt_pin_in,
  output logic serial_tx,
  output logic serial_rx_default_pin_in,
  output logic serial_rx_alt_pin_in,
  output logic [5:0] waveform_out,
  output logic capture_timer_out
);
  // Alternative pins show lvl and default pins its inverse, so a wrong pick never looks right
  assign {break_pin_alt_in, logic_table_zero_out, logic_table_one_out, serial_tx, capture_timer_out} = {5{lvl}};
  assign {break_pin_default_in, two_wire_scl_oe_n, two_wire_sda_oe_n, serial_rx_default_pin_in} = {4{~lvl}};
  assign serial_rx_alt_pin_in = lvl;
  assign event_signals = {3{lvl}};
  assign two_wire_default_pin_in = {2{~lvl}};
  assign two_wire_alt_pin_in = {2{lvl}};
  assign spi_out = {2{lvl}};
  assign spi_default_pin_in = {2{~lvl}};
  assign spi_alt_pin_in = {2{lvl}};
  assign waveform_out = {6{lvl}};
endmodule // ppsel_pin_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the pin position selector with its far-side model.
// Assumes registered outputs one cycle after inputs and rdata one cycle after rd_stb.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [31:0] w; logic s; logic p; logic [31:0] rb;} ppsel_row_s;
  logic ref_clk, rstn, wr_stb, rd_stb, timer_split_mode, lvl;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  logic break_pin_default_in, break_pin_alt_in, logic_table_zero_out, logic_table_one_out, two_wire_scl_oe_n;
  logic two_wire_sda_oe_n, serial_tx, serial_rx_default_pin_in, serial_rx_alt_pin_in, capture_timer_out;
  logic [1:0] two_wire_default_pin_in, two_wire_alt_pin_in, spi_out, spi_default_pin_in, spi_alt_pin_in;
  logic [2:0] event_signals, event_output_pins_ff;
  logic [5:0] waveform_out, waveform_default_pin_ff, waveform_alt_pin_ff;
  logic break_to_timer_ff, logic_table_zero_default_pin_ff, logic_table_zero_alt_pin_ff;
  logic logic_table_one_default_pin_ff, logic_table_one_alt_pin_ff, serial_tx_default_pin_ff;
  logic serial_tx_alt_pin_ff, serial_rx_ff, capture_timer_default_pin_ff, capture_timer_alt_pin_ff;
  logic [1:0] two_wire_default_oe_n_ff, two_wire_alt_oe_n_ff, two_wire_in_ff;
  logic [1:0] spi_default_pin_ff, spi_alt_pin_ff, spi_in_ff;
  logic [36:0] obs;
  int n_errors = 0;
  int total_checks = 0;
  // Register bytes packed {r3,r2,r1,r0}; rb is the masked readback
  ppsel_row_s rows [7] = '{
    '{32'hffff_ffff, 1'h1, 1'h1, 32'h013f_15b7}, '{32'hffff_ffff, 1'h0, 1'h1, 32'h013f_15b7},
    '{32'h0000_0000, 1'h1, 1'h1, 32'h0000_0000}, '{32'hfe55_aa5a, 1'h1, 1'h0, 32'h0015_0012},
    '{32'h01aa_55a5, 1'h1, 1'h1, 32'h012a_15a5}, '{32'h01aa_55a5, 1'h0, 1'h1, 32'h012a_15a5},
    '{32'h01aa_55a5, 1'h1, 1'h0, 32'h012a_15a5}};

  ppsel_top DUT (.ref_clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .timer_split_mode,
    .break_pin_default_in, .break_pin_alt_in, .break_to_timer_ff, .logic_table_zero_out, .logic_table_one_out,
    .logic_table_zero_default_pin_ff, .logic_table_zero_alt_pin_ff, .logic_table_one_default_pin_ff,
    .logic_table_one_alt_pin_ff, .event_signals, .event_output_pins_ff, .two_wire_scl_oe_n, .two_wire_sda_oe_n,
    .two_wire_default_oe_n_ff, .two_wire_alt_oe_n_ff, .two_wire_default_pin_in, .two_wire_alt_pin_in,
    .two_wire_in_ff, .spi_out, .spi_default_pin_ff, .spi_alt_pin_ff, .spi_default_pin_in, .spi_alt_pin_in,
    .spi_in_ff, .serial_tx, .serial_tx_default_pin_ff, .serial_tx_alt_pin_ff, .serial_rx_default_pin_in,
    .serial_rx_alt_pin_in, .serial_rx_ff, .waveform_out, .waveform_default_pin_ff, .waveform_alt_pin_ff,
    .capture_timer_out, .capture_timer_default_pin_ff, .capture_timer_alt_pin_ff);

  ppsel_pin_model u_pins (.lvl, .break_pin_default_in, .break_pin_alt_in, .logic_table_zero_out,
    .logic_table_one_out, .event_signals, .two_wire_scl_oe_n, .two_wire_sda_oe_n, .two_wire_default_pin_in,
    .two_wire_alt_pin_in, .spi_out, .spi_default_pin_in, .spi_alt_pin_in, .serial_tx, .serial_rx_default_pin_in,
    .serial_rx_alt_pin_in, .waveform_out, .capture_timer_out);

  assign obs = {break_to_timer_ff, logic_table_one_alt_pin_ff, logic_table_zero_alt_pin_ff, event_output_pins_ff,
    two_wire_alt_oe_n_ff, two_wire_in_ff, spi_alt_pin_ff, spi_in_ff, serial_tx_alt_pin_ff, serial_rx_ff,
    waveform_alt_pin_ff, capture_timer_alt_pin_ff, logic_table_one_default_pin_ff, logic_table_zero_default_pin_ff,
    two_wire_default_oe_n_ff, spi_default_pin_ff, serial_tx_default_pin_ff, waveform_default_pin_ff,
    capture_timer_default_pin_ff};

  initial ref_clk = 1'h0;
  always #25 ref_clk = ~ref_clk;

  function automatic logic [36:0] exp_pins(input logic [31:0] r, input logic s, input logic p);
    logic [5:0] w;
    // Upper three waveform selects count only in split mode
    w = {r[21:19] & {3{s}}, r[18:16]};
    exp_pins = {r[7] ~^ p, r[5] & p, r[4] & p, r[2:0] & {3{p}}, r[12] ? {2{~p}} : 2'h3, {2{r[12] ~^ p}},
      {2{r[10] & p}}, {2{r[10] ~^ p}}, r[8] & p, r[8] ~^ p, w & {6{p}}, r[24] & p,
      ~r[5] & p, ~r[4] & p, r[12] ? 2'h3 : {2{~p}}, {2{~r[10] & p}}, ~r[8] & p, ~w & {6{p}}, ~r[24] & p};
  endfunction

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_stb <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_stb <= 1'h0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    rd_stb <= 1'h1;
    addr <= a;
    @(posedge ref_clk);
    rd_stb <= 1'h0;
    #1;
    chk("rdata", 64'(rdata), 64'(e));
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("Error watchdog expected done seen running");
    stop_test();
  end

  initial begin
    {rstn, wr_stb, rd_stb, addr, wdata, timer_split_mode} = '0;
    lvl = 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("reset pins", 64'(obs), 64'(37'h0_7800_0c00));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    timer_split_mode <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      rd(2'(k), 8'h00);
    end
    chk("idle pins", 64'(obs), 64'(exp_pins(32'h0000_0000, 1'h1, 1'h1)));
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 4; k++) begin
        wr(2'(k), rows[i].w[8*k +: 8]);
      end
      timer_split_mode <= rows[i].s;
      lvl <= rows[i].p;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("pins", 64'(obs), 64'(exp_pins(rows[i].rb, rows[i].s, rows[i].p)));
      for (int k = 0; k < 4; k++) begin
        rd(2'(k), rows[i].rb[8*k +: 8]);
      end
    end
    // Write then read with no gap; the new select reaches the pins one cycle after the register
    lvl <= 1'h1;
    wr(2'h1, 8'h00);
    @(posedge ref_clk);
    wr_stb <= 1'h1;
    wdata <= 8'h04;
    @(posedge ref_clk);
    wr_stb <= 1'h0;
    rd_stb <= 1'h1;
    #1;
    chk("spi alt early", 64'(spi_alt_pin_ff), 64'(2'h0));
    @(posedge ref_clk);
    rd_stb <= 1'h0;
    #1;
    chk("rdata b2b", 64'(rdata), 64'(8'h04));
    chk("spi alt", 64'(spi_alt_pin_ff), 64'(2'h3));
    @(posedge ref_clk);
    #1;
    chk("rdata idle", 64'(rdata), 64'(8'h00));
    // Reset in mid-run, away from the clock edge
    #7;
    rstn = 1'h0;
    #1;
    chk("mid reset pins", 64'(obs), 64'(37'h0_7800_0c00));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'h1;
    for (int k = 0; k < 4; k++) begin
      rd(2'(k), 8'h00);
    end
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
